// [design/sdb_pkg.sv]
// Package with register map, field layout, reset values and timing for the shared diag bank.
package sdb_pkg;

    // Register indices; the byte address of each register is four times its index.
    localparam logic [7:0] IDX_IND_CTL = 8'h00_B0;
    localparam logic [7:0] IDX_IND_OFFSET = 8'h00_B1;
    localparam logic [7:0] IDX_IND_DATA = 8'h00_B2;
    localparam logic [7:0] IDX_SELF_TEST = 8'h00_B3;
    localparam logic [7:0] IDX_RSVD_B4 = 8'h00_B4;
    localparam logic [7:0] IDX_RSVD_B5 = 8'h00_B5;
    localparam logic [7:0] IDX_RSVD_B6 = 8'h00_B6;
    localparam logic [7:0] IDX_RSVD_B7 = 8'h00_B7;
    localparam logic [7:0] IDX_STRAP_STS = 8'h00_B8;
    localparam logic [7:0] IDX_LINK_POLICY = 8'h00_B9;

    // Reset values.
    localparam logic [3:0] RST_TARGET_SEL = 4'h7;
    localparam logic [7:0] RST_IND_OFFSET = 8'h3A;
    localparam logic [7:0] RST_IND_DATA = 8'h14;
    localparam logic [7:0] RST_SELF_TEST = 8'h08;
    localparam logic [7:0] RST_RSVD_B4 = 8'h25;
    localparam logic [7:0] RST_RSVD_B5 = 8'h00;
    localparam logic [7:0] RST_RSVD_B6 = 8'h18;
    localparam logic [7:0] RST_RSVD_B7 = 8'h00;
    localparam logic [7:0] RST_LINK_POLICY = 8'h33;

    // Indirect control fields.
    localparam int CTL_SEL_LSB = 2;
    localparam int CTL_AUTO_INC_BIT = 1;
    localparam int CTL_PREFETCH_BIT = 0;

    // Self-test control fields.
    localparam int ST_MODE_LSB = 6;
    localparam int ST_CFG_BIT = 3;
    localparam int ST_CLKSRC_LSB = 1;
    localparam int ST_EN_BIT = 0;
    localparam logic [1:0] ST_MODE_QUIET = 2'h0;
    localparam logic [1:0] ST_MODE_ALT = 2'h1;

    // Strap status fields.
    localparam int STS_INDEX_STRAP_DONE_BIT = 7;
    localparam int STS_IDX_LSB = 4;
    localparam int STS_MODE_DONE_BIT = 3;
    localparam int STS_MODE_LSB = 0;

    // Link error policy fields.
    localparam int LP_WAIT_IGNORE_BIT = 5;
    localparam int LP_COUNT_EN_BIT = 4;
    localparam int LP_THRESH_LSB = 0;

    // Offset of the clock source bits inside the remote serializer.
    localparam logic [7:0] REMOTE_CLKSRC_OFFSET = 8'h14;

    // Timing: core clock period and strap settle time before capture.
    localparam int CLK_PERIOD_NS = 20;
    localparam int STRAP_SETTLE_NS = 1000;
    localparam int STRAP_SETTLE_CYC = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// [design/sdb_strap_latch.sv]
// Strap capture: synchronises a 3-bit strap decode, waits to settle, latches it once.
`timescale 1ns/1ns
module sdb_strap_latch (
    // Clock and synchronised reset.
    input wire logic clk_in,
    input wire logic rst_b_in,
    // Strap decode from the pin decoder.
    input wire logic [2:0] strap_in,
    // Latched result.
    output logic [2:0] value_out,
    output logic done_out
);

    typedef struct packed {
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic [7:0] settle;
        logic [2:0] value;
        logic done;
    } sdb_strap_st_t;

    sdb_strap_st_t st_r;
    sdb_strap_st_t st_nxt;

    // Count settle cycles after reset release, then freeze the value so later pin noise is moot.
    always_comb begin
        st_nxt = st_r;
        st_nxt.sync1 = strap_in;
        st_nxt.sync2 = st_r.sync1;
        if (!st_r.done) begin
            if (st_r.settle == 8'(sdb_pkg::STRAP_SETTLE_CYC - 1)) begin
                st_nxt.value = st_r.sync2;
                st_nxt.done = 1'b1;
            end else begin
                st_nxt.settle = st_r.settle + 8'h01;
            end
        end
    end

    // State register.
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign value_out = st_r.value;
    assign done_out = st_r.done;

endmodule

// [design/sdb_bank.sv]
// Shared diagnostic register bank: indirect window, self-test, strap status, link error policy.
`timescale 1ns/1ns
// Contract
// R1 - 8-bit read/write indirect offset register, reset 0x3A.
// R2 - Writing indirect data writes that byte to selected block at offset.
// R3 - Reading indirect data returns live block contents at the offset.
// R4 - 4-bit target select, reset 0x7, chooses the indirect target block.
// R5 - Auto-increment adds one to offset after each indirect read or write.
// R6 - Prefetch bit issues a read strobe whenever the offset is written.
// R7 - Auto-increment plus prefetch also strobes a read after each data read.
// R8 - Output mode: 00 quiet, 01 alternating, 1x follows self-test data.
// R9 - Software must clear the configuration bit to use the low control bits.
// R10 - Enable starts self-test and writes clock source to remote offset 0x14.
// R11 - Index strap decode latched into read-only bits 6:4.
// R12 - Bit 7 reads one once the index decode is latched.
// R13 - Mode strap decode latched into read-only bits 2:0.
// R14 - Bit 3 reads one once the mode decode is latched.
// R15 - Wait-ignore bit set: errors during adaptation wait period are disregarded.
// R16 - Count enable bit, reset one, switches the error counter on.
// R17 - Counter enabled: lock lost when count reaches threshold, reset 0x3.
// R18 - Counter disabled: lock lost on first link error.
// R19 - Errors counted on both embedded clock bits, parity and balance bit.
// R20 - Counter checks once per received word.
// R21 - Counter clears on loss of lock and on lock reacquisition.
module sdb_bank (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_b_in,
    // APB slave.
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Indirect window towards internal register blocks.
    input wire logic [7:0] ind_rdata_in,
    output logic [3:0] ind_target_out,
    output logic [7:0] ind_offset_out,
    output logic [7:0] ind_wdata_out,
    output logic ind_wr_out,
    output logic ind_rd_out,
    // Self-test.
    input wire logic st_data_in,
    output logic st_active_out,
    output logic st_toggle_out,
    output logic remote_wr_out,
    output logic [7:0] remote_offset_out,
    output logic [1:0] remote_clksrc_out,
    // Strap pin decodes, asynchronous.
    input wire logic [2:0] idx_strap_in,
    input wire logic [2:0] mode_strap_in,
    // Forward link word checks, one cycle enable per received word.
    input wire logic word_valid_in,
    input wire logic embedded_clock_bit_a_err_in,
    input wire logic embedded_clock_bit_b_err_in,
    input wire logic parity_err_in,
    input wire logic dc_balance_bit_err_in,
    input wire logic adapt_wait_in,
    input wire logic lock_acquired_in,
    output logic locked_out,
    output logic lock_lost_out
);

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [3:0] target;
        logic auto_inc;
        logic prefetch;
        logic [7:0] offset;
        logic [7:0] wdata;
        logic ind_wr;
        logic ind_rd;
        logic [7:0] self_test;
        logic st_active;
        logic st_toggle;
        logic alt;
        logic remote_wr;
        logic [1:0] remote_clksrc;
        logic [7:0] policy;
        logic [3:0] err_count;
        logic locked;
        logic lock_lost;
    } sdb_state_t;

    sdb_state_t st_r;
    sdb_state_t st_nxt;
    logic [1:0] rst_sync_r;
    logic rst_b;
    logic [2:0] idx_value;
    logic index_strap_done;
    logic [2:0] mode_value;
    logic mode_done;
    logic [7:0] reg_index;
    logic addr_ok;
    logic access;
    logic [7:0] rd_byte;
    logic hit;
    logic [3:0] err_next;
    logic [3:0] thresh;
    logic st_go;

    // Reset release through two flops so every other flop leaves reset on the same edge.
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_b = rst_sync_r[1];

    // Strap capture for the index and mode pins.
    sdb_strap_latch u_idx_strap (
        .clk_in(clk_in),
        .rst_b_in(rst_b),
        .strap_in(idx_strap_in),
        .value_out(idx_value),
        .done_out(index_strap_done)
    );

    sdb_strap_latch u_mode_strap (
        .clk_in(clk_in),
        .rst_b_in(rst_b),
        .strap_in(mode_strap_in),
        .value_out(mode_value),
        .done_out(mode_done)
    );

    // Address decode: word aligned, index is the byte address divided by four.
    assign reg_index = paddr_in[9:2];
    assign addr_ok = (paddr_in[1:0] == 2'h0) && (paddr_in[11:10] == 2'h0);
    assign access = psel_in && penable_in;
    assign thresh = st_r.policy[sdb_pkg::LP_THRESH_LSB +: 4];
    assign st_go = st_r.self_test[sdb_pkg::ST_EN_BIT] && !st_r.self_test[sdb_pkg::ST_CFG_BIT];

    // Read mux; the data window reads the target live rather than a stored copy.
    always_comb begin
        rd_byte = 8'h00;
        hit = addr_ok;
        case (reg_index)
            sdb_pkg::IDX_IND_CTL: begin
                rd_byte = {2'h0, st_r.target, st_r.auto_inc, st_r.prefetch};
            end
            sdb_pkg::IDX_IND_OFFSET: begin
                rd_byte = st_r.offset; // see R1
            end
            sdb_pkg::IDX_IND_DATA: begin
                rd_byte = ind_rdata_in; // see R3
            end
            sdb_pkg::IDX_SELF_TEST: begin
                rd_byte = st_r.self_test;
            end
            sdb_pkg::IDX_RSVD_B4: begin
                rd_byte = sdb_pkg::RST_RSVD_B4;
            end
            sdb_pkg::IDX_RSVD_B5: begin
                rd_byte = sdb_pkg::RST_RSVD_B5;
            end
            sdb_pkg::IDX_RSVD_B6: begin
                rd_byte = sdb_pkg::RST_RSVD_B6;
            end
            sdb_pkg::IDX_RSVD_B7: begin
                rd_byte = sdb_pkg::RST_RSVD_B7;
            end
            sdb_pkg::IDX_STRAP_STS: begin
                rd_byte = {index_strap_done, idx_value, mode_done, mode_value}; // see R11 R12 R13 R14
            end
            sdb_pkg::IDX_LINK_POLICY: begin
                rd_byte = {2'h0, st_r.policy[5:0]};
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // Next state: APB, indirect window, self-test and link error policy.
    always_comb begin
        st_nxt = st_r;
        st_nxt.ind_wr = 1'b0;
        st_nxt.ind_rd = 1'b0;
        st_nxt.remote_wr = 1'b0;
        err_next = st_r.err_count;

        // First access cycle samples read data; the next edge completes the transfer.
        if (access && !st_r.pready) begin
            st_nxt.pready = 1'b1;
            st_nxt.pslverr = !hit;
            st_nxt.prdata = (hit && !pwrite_in) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end else if (access && st_r.pready) begin
            st_nxt.pready = 1'b0;
            st_nxt.pslverr = 1'b0;
            if (hit && pwrite_in) begin
                case (reg_index)
                    sdb_pkg::IDX_IND_CTL: begin
                        st_nxt.target = pwdata_in[sdb_pkg::CTL_SEL_LSB +: 4]; // see R4
                        st_nxt.auto_inc = pwdata_in[sdb_pkg::CTL_AUTO_INC_BIT];
                        st_nxt.prefetch = pwdata_in[sdb_pkg::CTL_PREFETCH_BIT];
                    end
                    sdb_pkg::IDX_IND_OFFSET: begin
                        st_nxt.offset = pwdata_in[7:0]; // see R1
                        st_nxt.ind_rd = st_r.prefetch; // see R6
                    end
                    sdb_pkg::IDX_IND_DATA: begin
                        st_nxt.wdata = pwdata_in[7:0];
                        st_nxt.ind_wr = 1'b1; // see R2
                    end
                    sdb_pkg::IDX_SELF_TEST: begin
                        // Bits 5:4 are reserved and stay zero.
                        st_nxt.self_test = pwdata_in[7:0] & 8'hCF;
                    end
                    sdb_pkg::IDX_LINK_POLICY: begin
                        st_nxt.policy = {2'h0, pwdata_in[5:0]};
                    end
                    default: begin
                        st_nxt.policy = st_r.policy;
                    end
                endcase
            end else if (hit && (reg_index == sdb_pkg::IDX_IND_DATA)) begin
                // Completed data read: with auto-increment, step the offset and optionally prefetch the next one.
                if (st_r.auto_inc) begin
                    st_nxt.offset = st_r.offset + 8'h01; // see R5
                    st_nxt.ind_rd = st_r.prefetch; // see R7
                end
            end
        end else begin
            st_nxt.pready = 1'b0;
            st_nxt.pslverr = 1'b0;
        end

        // The write strobe takes the old offset, so the increment lands one cycle later.
        if (st_r.ind_wr && st_r.auto_inc) begin
            st_nxt.offset = st_r.offset + 8'h01; // see R5
        end

        // Self-test runs only with the configuration bit cleared by software.
        st_nxt.st_active = st_go; // see R9 R10
        if (st_go && !st_r.st_active) begin
            st_nxt.remote_wr = 1'b1; // see R10
            st_nxt.remote_clksrc = st_r.self_test[sdb_pkg::ST_CLKSRC_LSB +: 2];
        end
        st_nxt.alt = st_go ? !st_r.alt : 1'b0;
        if (!st_go || (st_r.self_test[sdb_pkg::ST_MODE_LSB +: 2] == sdb_pkg::ST_MODE_QUIET)) begin
            st_nxt.st_toggle = 1'b0; // see R8
        end else if (st_r.self_test[sdb_pkg::ST_MODE_LSB +: 2] == sdb_pkg::ST_MODE_ALT) begin
            st_nxt.st_toggle = st_r.alt; // see R8
        end else begin
            st_nxt.st_toggle = st_data_in; // see R8
        end

        // Link error policy; a threshold of zero behaves like one so lock never drops without an error.
        st_nxt.lock_lost = 1'b0;
        if (lock_acquired_in && !st_r.locked) begin
            st_nxt.locked = 1'b1;
            st_nxt.err_count = 4'h0; // see R21
        end else if (st_r.locked && word_valid_in && // see R20
                     (embedded_clock_bit_a_err_in || embedded_clock_bit_b_err_in ||
                      parity_err_in || dc_balance_bit_err_in) && // see R19
                     !(adapt_wait_in && st_r.policy[sdb_pkg::LP_WAIT_IGNORE_BIT])) begin // see R15
            err_next = st_r.err_count + 4'h1;
            if (!st_r.policy[sdb_pkg::LP_COUNT_EN_BIT] || (err_next >= thresh)) begin // see R16 R17 R18
                st_nxt.locked = 1'b0;
                st_nxt.lock_lost = 1'b1;
                st_nxt.err_count = 4'h0; // see R21
            end else begin
                st_nxt.err_count = err_next; // see R17
            end
        end
    end

    // State register with documented reset values.
    always_ff @(posedge clk_in or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '0;
            st_r.target <= sdb_pkg::RST_TARGET_SEL; // see R4
            st_r.offset <= sdb_pkg::RST_IND_OFFSET; // see R1
            st_r.wdata <= sdb_pkg::RST_IND_DATA;
            st_r.self_test <= sdb_pkg::RST_SELF_TEST;
            st_r.policy <= sdb_pkg::RST_LINK_POLICY; // see R16 R17
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from flops, except the remote offset, which is a constant.
    assign prdata_out = st_r.prdata;
    assign pready_out = st_r.pready;
    assign pslverr_out = st_r.pslverr;
    assign ind_target_out = st_r.target;
    assign ind_offset_out = st_r.offset;
    assign ind_wdata_out = st_r.wdata;
    assign ind_wr_out = st_r.ind_wr;
    assign ind_rd_out = st_r.ind_rd;
    assign st_active_out = st_r.st_active;
    assign st_toggle_out = st_r.st_toggle;
    assign remote_wr_out = st_r.remote_wr;
    assign remote_offset_out = sdb_pkg::REMOTE_CLKSRC_OFFSET; // Constant offset, never changes.
    assign remote_clksrc_out = st_r.remote_clksrc;
    assign locked_out = st_r.locked;
    assign lock_lost_out = st_r.lock_lost;

endmodule

// [tb/sdb_bank_assertions.sv]
// Checker of port timing for the shared diagnostic register bank.
`timescale 1ns/1ns
module sdb_bank_assertions (
    // Clock, reset and register bus.
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    // Indirect window, self-test and link outputs.
    input wire logic [7:0] ind_offset_out,
    input wire logic [7:0] ind_wdata_out,
    input wire logic ind_wr_out,
    input wire logic st_active_out,
    input wire logic remote_wr_out,
    input wire logic [7:0] remote_offset_out,
    input wire logic word_valid_in,
    input wire logic locked_out,
    input wire logic lock_lost_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    // An access phase that the slave has not yet answered.
    sequence take_s;
        psel_in && penable_in && !pready_out;
    endsequence
    // A write taken at one register address.
    sequence wr_s(logic [11:0] a);
        take_s ##0 (pwrite_in && paddr_in == a);
    endsequence

    apb_answer_a: assert property (take_s |=> pready_out)
        else $error("bus access not answered in the next cycle");
    ready_pulse_a: assert property (pready_out |=> !pready_out)
        else $error("ready held longer than one cycle");
    unmapped_err_a: assert property (take_s ##0 (paddr_in[1:0] != 2'h0 ||
        paddr_in[11:10] != 2'h0) |=> pslverr_out && prdata_out == 32'h0000_0000)
        else $error("bad address not refused");
    data_write_a: assert property (wr_s(12'h2C8) |-> ##2 ind_wr_out &&
        ind_wdata_out == $past(pwdata_in[7:0], 2))
        else $error("indirect data write not forwarded");
    offset_write_a: assert property (wr_s(12'h2C4) |-> ##2
        ind_offset_out == $past(pwdata_in[7:0], 2))
        else $error("offset write not applied");
    remote_push_a: assert property ($rose(st_active_out) |-> remote_wr_out &&
        remote_offset_out == 8'h14 ##1 !remote_wr_out)
        else $error("clock source not pushed on self-test start");
    lock_lost_a: assert property (lock_lost_out |-> !locked_out &&
        $past(locked_out) && $past(word_valid_in))
        else $error("loss reported without a locked word");
    drop_report_a: assert property ($fell(locked_out) |-> lock_lost_out)
        else $error("lock dropped silently");
    unlocked_quiet_a: assert property (!locked_out |=> !lock_lost_out)
        else $error("loss reported while unlocked");
endmodule

// [tb/sdb_target_model.sv]
// Model of the internal register blocks and of the remote serializer register.
`timescale 1ns/1ns
module sdb_target_model (
    // Clock.
    input wire logic clk_in,
    // Indirect window from the bank.
    input wire logic [3:0] ind_target_in,
    input wire logic [7:0] ind_offset_in,
    input wire logic [7:0] ind_wdata_in,
    input wire logic ind_wr_in,
    input wire logic ind_rd_in,
    output logic [7:0] ind_rdata_out,
    // Remote serializer write.
    input wire logic remote_wr_in,
    input wire logic [7:0] remote_offset_in,
    input wire logic [1:0] remote_clksrc_in,
    output logic [1:0] clksrc_seen_out,
    output logic [7:0] rd_count_out
);
    logic [7:0] mem [16][256];

    // Each byte starts as a pattern of block and offset, so a wrong target shows.
    initial begin
        for (int t = 0; t < 16; t++) begin
            for (int o = 0; o < 256; o++) begin
                mem[t][o] = 8'(t * 16) ^ 8'(o);
            end
        end
        clksrc_seen_out = 2'h0;
        rd_count_out = 8'h00;
    end

    // Reads are live, never a cached copy.
    assign ind_rdata_out = mem[ind_target_in][ind_offset_in];

    // Writes, read strobes and the remote clock source land on the clock edge.
    always @(posedge clk_in) begin
        if (ind_wr_in) begin
            mem[ind_target_in][ind_offset_in] <= ind_wdata_in;
        end
        if (ind_rd_in) begin
            rd_count_out <= rd_count_out + 8'h01;
        end
        if (remote_wr_in && remote_offset_in == 8'h14) begin
            clksrc_seen_out <= remote_clksrc_in;
        end
    end
endmodule

// [tb/tb.sv]
// Testbench for the shared diagnostic register bank.
`timescale 1ns/1ns
module tb;
    logic clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] rdata;
    logic [3:0] tgt;
    logic [7:0] off;
    logic [7:0] wdata;
    logic iwr;
    logic ird;
    logic st_data = 1'b0;
    logic st_act;
    logic st_tog;
    logic rwr;
    logic [7:0] roff;
    logic [1:0] rclk;
    logic [1:0] clk_seen;
    logic [7:0] rdc;
    logic wv = 1'b0;
    logic [3:0] errs = 4'h0;
    logic aw = 1'b0;
    logic lacq = 1'b0;
    logic locked;
    logic lost;
    logic [31:0] q;
    logic err;
    logic [7:0] n;
    logic a;
    logic [7:0] rsv [4] = '{8'h25, 8'h00, 8'h18, 8'h00};
    int n_errors = 0;
    int tests_run = 0;

    sdb_bank u_sdb_bank (.clk_in(clk_in), .rst_b_in(rst_b_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .ind_rdata_in(rdata), .ind_target_out(tgt), .ind_offset_out(off),
        .ind_wdata_out(wdata), .ind_wr_out(iwr), .ind_rd_out(ird), .st_data_in(st_data),
        .st_active_out(st_act), .st_toggle_out(st_tog), .remote_wr_out(rwr),
        .remote_offset_out(roff), .remote_clksrc_out(rclk), .idx_strap_in(3'h5),
        .mode_strap_in(3'h2), .word_valid_in(wv), .embedded_clock_bit_a_err_in(errs[0]),
        .embedded_clock_bit_b_err_in(errs[1]), .parity_err_in(errs[2]),
        .dc_balance_bit_err_in(errs[3]), .adapt_wait_in(aw), .lock_acquired_in(lacq),
        .locked_out(locked), .lock_lost_out(lost));

    sdb_target_model u_sdb_target_model (.clk_in(clk_in), .ind_target_in(tgt),
        .ind_offset_in(off), .ind_wdata_in(wdata), .ind_wr_in(iwr), .ind_rd_in(ird),
        .ind_rdata_out(rdata), .remote_wr_in(rwr), .remote_offset_in(roff),
        .remote_clksrc_in(rclk), .clksrc_seen_out(clk_seen), .rd_count_out(rdc));

    // Free-running 50 MHz clock.
    always #10 clk_in = ~clk_in;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("checks=%0d errors=%0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // One bus transfer: setup, then access until pready is seen high at a rising edge.
    // The transfer completes, and read data is taken, at that edge; only then is the request released.
    task automatic apb(input logic w, input logic [11:0] ad, input logic [7:0] d);
        int i;
        @(posedge clk_in);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= {24'h00_0000, d};
        @(posedge clk_in);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clk_in);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (i >= 20) begin
            n_errors++;
            summarize();
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, {2'b00, idx, 2'b00}, d);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        apb(1'b0, {2'b00, idx, 2'b00}, 8'h00);
        chk(q, {24'h00_0000, exp});
    endtask

    // One received word; the adaptation wait level is left as set.
    task automatic word(input logic [3:0] ev, input logic w);
        @(posedge clk_in);
        wv <= 1'b1;
        errs <= ev;
        aw <= w;
        @(posedge clk_in);
        wv <= 1'b0;
        errs <= 4'h0;
    endtask

    // Acquire lock, then send errored words; lock must hold while fewer than thr.
    task automatic lockrun(input int cnt, input logic [3:0] ev, input logic w, input int thr);
        @(posedge clk_in);
        lacq <= 1'b1;
        @(posedge clk_in);
        lacq <= 1'b0;
        for (int k = 1; k <= cnt; k++) begin
            word(ev, w);
            @(negedge clk_in);
            chk(locked, k < thr);
        end
    endtask

    // Main sequence.
    initial begin
        repeat (20) @(posedge clk_in);
        rst_b_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        rd(8'hB0, 8'h1C);
        rd(8'hB1, 8'h3A);
        rd(8'hB2, 8'h4A);
        rd(8'hB3, 8'h08);
        rd(8'hB9, 8'h33);
        for (int i = 0; i < 4; i++) begin
            wr(8'hB4 + 8'(i), 8'hFF);
            rd(8'hB4 + 8'(i), rsv[i]);
        end
        apb(1'b0, 12'hC00, 8'h00);
        chk({q[30:0], err}, 32'h0000_0001);
        apb(1'b1, 12'h2C6, 8'h99);
        chk({31'h0000_0000, err}, 32'h0000_0001);
        rd(8'hB1, 8'h3A);
        // Indirect window on block 3 with auto-increment.
        wr(8'hB0, 8'h0E);
        wr(8'hB1, 8'h10);
        wr(8'hB2, 8'h55);
        repeat (2) @(posedge clk_in);
        chk(u_sdb_target_model.mem[3][16], 8'h55);
        rd(8'hB1, 8'h11);
        rd(8'hB2, 8'h21);
        u_sdb_target_model.mem[3][16] = 8'hA5;
        wr(8'hB1, 8'h10);
        rd(8'hB2, 8'hA5);
        // Prefetch strobes on offset write and after a data read.
        n = rdc;
        wr(8'hB0, 8'h0F);
        wr(8'hB1, 8'h20);
        rd(8'hB2, 8'h10);
        repeat (2) @(posedge clk_in);
        chk({24'h00_0000, rdc - n}, 32'h0000_0002);
        // Self-test stays blocked while the configuration bit is set.
        // The active flag follows the register one cycle after the write lands.
        wr(8'hB3, 8'h0D);
        repeat (2) @(negedge clk_in);
        chk(st_act, 1'b0);
        wr(8'hB3, 8'h04);
        wr(8'hB3, 8'h05);
        repeat (2) @(negedge clk_in);
        chk(st_act, 1'b1);
        chk(st_tog, 1'b0);
        @(negedge clk_in);
        chk(clk_seen, 2'h2);
        wr(8'hB3, 8'h45);
        repeat (2) @(negedge clk_in);
        a = st_tog;
        @(negedge clk_in);
        chk(st_tog, !a);
        for (int m = 2; m < 4; m++) begin
            wr(8'hB3, {2'(m), 6'h05});
            @(posedge clk_in);
            st_data <= 1'b1;
            repeat (3) @(negedge clk_in);
            chk(st_tog, 1'b1);
            @(posedge clk_in);
            st_data <= 1'b0;
            repeat (3) @(negedge clk_in);
            chk(st_tog, 1'b0);
        end
        rd(8'hB8, 8'hDA);
        // Lock loss policy.
        lockrun(3, 4'h1, 1'b0, 3);
        lockrun(3, 4'h2, 1'b0, 3);
        lockrun(3, 4'h4, 1'b1, 9);
        wr(8'hB9, 8'h13);
        lockrun(3, 4'h8, 1'b1, 3);
        wr(8'hB9, 8'h25);
        lockrun(1, 4'h9, 1'b0, 1);
        wr(8'hB9, 8'h31);
        lockrun(1, 4'h2, 1'b0, 1);
        summarize();
    end
endmodule

bind sdb_bank sdb_bank_assertions u_sdb_bank_assertions (.clk_in(clk_in),
    .rst_b_in(rst_b_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .ind_offset_out(ind_offset_out), .ind_wdata_out(ind_wdata_out),
    .ind_wr_out(ind_wr_out), .st_active_out(st_active_out),
    .remote_wr_out(remote_wr_out), .remote_offset_out(remote_offset_out),
    .word_valid_in(word_valid_in), .locked_out(locked_out),
    .lock_lost_out(lock_lost_out));
